// File: rtl/fan_limit_pkg.sv
// shared constants, types and helpers for the fan zone limit and tach mode registers
package fan_limit_pkg;

  // register offsets on the management register port
  localparam logic [7:0] ADDR_ABS1 = 8'h6a;
  localparam logic [7:0] ADDR_ABS2 = 8'h6b;
  localparam logic [7:0] ADDR_ABS3 = 8'h6c;
  localparam logic [7:0] ADDR_HYST12 = 8'h6d;
  localparam logic [7:0] ADDR_HYST3 = 8'h6e;
  localparam logic [7:0] ADDR_TEST = 8'h6f;
  localparam logic [7:0] ADDR_TACH = 8'h74;

  // reset values
  localparam logic [7:0] RST_ABS = 8'h64;
  localparam logic [7:0] RST_HYST12 = 8'h44;
  localparam logic [7:0] RST_HYST3 = 8'h40;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_TACH = 8'h00;
  localparam logic [7:0] RD_UNDEFINED = 8'h00;

  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_HYST3 = 8'hf0;
  localparam logic [7:0] MASK_TEST = 8'h01;
  localparam logic [7:0] MASK_TACH = 8'h3f;

  // field positions
  localparam int HYST1_LSB = 4;
  localparam int HYST2_LSB = 0;
  localparam int HYST3_LSB = 4;
  localparam int XEN_BIT = 0;
  localparam int FAN_SPEED_INPUT_1_LSB = 0;
  localparam int FAN_SPEED_INPUT_2_LSB = 2;
  localparam int TACH34_LSB = 4;

  // limit code that switches the absolute-limit override off (-128 C)
  localparam logic [7:0] ABS_DISABLE = 8'h80;
  localparam logic [15:0] TACH_SATURATED = 16'hffff;
  localparam logic [1:0] PULSES_PER_REV = 2'h2;

  typedef enum logic [1:0] {
    TACH_PLAIN = 2'b00,
    TACH_FLAGGED = 2'b01,
    TACH_ACCURATE = 2'b10,
    TACH_QUIET = 2'b11
  } tach_mode_t;

  typedef enum logic {
    ZONE_IDLE = 1'b0,
    ZONE_ACTIVE = 1'b1
  } zone_state_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] absLimit;
    logic [3:0] hyst;
  } zone_cfg_t;

  typedef struct packed {
    logic lowSpeedExt;
    logic quietTune;
    logic saturate;
  } tach_ctl_t;

  // mode field of tach input idx (inputs 3 and 4 share one field)
  function automatic tach_mode_t tach_field(input logic [7:0] r, input logic [1:0] idx);
    case (idx)
      2'h0: tach_field = tach_mode_t'(r[FAN_SPEED_INPUT_1_LSB+:2]);
      2'h1: tach_field = tach_mode_t'(r[FAN_SPEED_INPUT_2_LSB+:2]);
      default: tach_field = tach_mode_t'(r[TACH34_LSB+:2]);
    endcase
  endfunction : tach_field

  // least detectable rpm for a tach mode and pwm frequency step
  function automatic logic [12:0] min_rpm(input tach_mode_t m, input logic [2:0] f);
    logic ext;
    ext = m[1];
    case (f)
      3'h0: min_rpm = ext ? 13'd210 : 13'd841;
      3'h1: min_rpm = ext ? 13'd315 : 13'd1262;
      3'h2: min_rpm = ext ? 13'd420 : 13'd1944;
      3'h3: min_rpm = ext ? 13'd420 : 13'd2523;
      3'h4: min_rpm = ext ? 13'd420 : 13'd3205;
      3'h5: min_rpm = ext ? 13'd420 : 13'd3953;
      3'h6: min_rpm = ext ? 13'd420 : 13'd5156;
      default: min_rpm = ext ? 13'd420 : 13'd7906;
    endcase
  endfunction : min_rpm

endpackage : fan_limit_pkg

// File: rtl/zone_fan_eval.sv
// per-zone fan limit, hysteresis and absolute-limit evaluation
`timescale 1ns/1ps
module zone_fan_eval (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // zone inputs
  input logic [7:0] temp,
  input logic [7:0] fanLimit,
  input fan_limit_pkg::zone_cfg_t cfg,
  // zone results
  output logic fanOn,
  output logic holdMin,
  output logic absOver
);
  import fan_limit_pkg::*;

  zone_state_t state;
  zone_state_t next_state;
  logic signed [8:0] lowEdge;
  logic signed [8:0] temp9;

  // all temperatures and limits are signed whole degrees
  assign temp9 = $signed({temp[7], temp}); // [R4]
  assign lowEdge = $signed({fanLimit[7], fanLimit}) - $signed({5'h00, cfg.hyst}); // [R8]
  assign fanOn = $signed(temp) >= $signed(fanLimit); // [R18]
  // strictly above the limit; the -128 code can never be exceeded meaningfully, so gate it
  assign absOver = (cfg.absLimit != ABS_DISABLE) && ($signed(temp) > $signed(cfg.absLimit)); // [R1] [R2]
  // between limit-hyst and limit the fan idles at minimum duty
  // the band edge is checked here too, so a drop straight past it never shows a one-cycle hold
  assign holdMin = (state == ZONE_ACTIVE) && !fanOn && (temp9 >= lowEdge); // [R7]

  // leave the active state only once below limit minus hysteresis
  always_comb begin
    next_state = state;
    case (state)
      ZONE_IDLE: if (fanOn) next_state = ZONE_ACTIVE;
      ZONE_ACTIVE: if (temp9 < lowEdge) next_state = ZONE_IDLE; // [R7]
      default: next_state = ZONE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ZONE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  property p_hold_exit;
    @(posedge clk) disable iff (!rst_n)
      (state == ZONE_ACTIVE && temp9 >= lowEdge) |=> (state == ZONE_ACTIVE);
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("zone left hold above hysteresis edge"); // [R7]

endmodule : zone_fan_eval

// File: rtl/fan_zone_limit_tach_mode_regs.sv
// absolute limit, hysteresis, test and tach mode register group with its decode
// Operation
// [R1] newer variant, auto mode: any zone above its absolute limit drives all PWMs full.
// [R2] absolute limit code 80h disables that zone's full-duty override.
// [R3] older variant: only the violating zone's PWM goes full, others untouched.
// [R4] absolute limits are signed two's-complement whole degrees Celsius.
// [R5] lock bit makes limit, hysteresis and test registers read-only, writes ignored.
// [R6] start bit clear: logic uses reset defaults while writes still get stored.
// [R7] after crossing fan limit, hold minimum duty until below limit minus hysteresis.
// [R8] hysteresis fields are 4-bit degrees: zone1 bits 7:4, zone2 3:0, zone3 7:4.
// [R9] test register bit 0 enters xor tree test mode; zero leaves it.
// [R10] vendor range has no defined power-up value unless a register gives one.
// [R11] tach mode fields: input1 bits 1:0, input2 bits 3:2, inputs 3/4 bits 5:4.
// [R12] fan speed results assume two tach pulses per revolution in every mode.
// [R13] mode 00 is plain detection; slow fans may report any value.
// [R14] modes 1 to 3 report all ones below minimum detectable speed.
// [R15] mode 10 extends low speed for accuracy, 11 for least PWM disturbance.
// [R16] minimum detectable speed follows PWM frequency; extended modes cap at 420 rpm.
// [R17] tach mode register ignores lock but defaults apply while start is clear.
// [R18] fan switches on when zone temperature equals its fan limit.
// [R19] undefined addresses read zero; writes there do nothing.
// [R20] reserved bits read zero and ignore written values.
`timescale 1ns/1ps
module fan_zone_limit_tach_mode_regs (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // register port
  input fan_limit_pkg::reg_req_t regReq,
  output logic [7:0] rdData,
  output logic rdValid,
  // control from the ready/lock/start register and device strap
  input logic lockBit,
  input logic startBit,
  input logic variantB,
  input logic [2:0] autoMode,
  // zone temperatures and fan limits
  input logic [2:0][7:0] zoneTemp,
  input logic [2:0][7:0] fanLimit,
  // zone results
  output logic [2:0] fullDuty,
  output logic [2:0] fanOn,
  output logic [2:0] holdMin,
  // test mode
  output logic xorTreeEnable,
  // tach inputs and results
  input logic [2:0] pwmFreqSel,
  input logic [3:0][15:0] tachRaw,
  input logic [3:0] tachSlow,
  output logic [3:0][15:0] tachReport,
  output fan_limit_pkg::tach_ctl_t [3:0] tachCtl,
  output logic [3:0][12:0] minRpm,
  output logic [1:0] pulsesPerRev
);
  import fan_limit_pkg::*;

  // stored register contents
  logic [2:0][7:0] absReg;
  logic [7:0] hyst12Reg;
  logic [7:0] hyst3Reg;
  logic [7:0] testReg;
  logic [7:0] tachReg;
  logic [2:0][7:0] next_absReg;
  logic [7:0] next_hyst12Reg;
  logic [7:0] next_hyst3Reg;
  logic [7:0] next_testReg;
  logic [7:0] next_tachReg;

  // values that the logic actually uses
  logic [2:0][7:0] absEff;
  logic [7:0] hyst12Eff;
  logic [7:0] hyst3Eff;
  logic [7:0] testEff;
  logic [7:0] tachEff;
  zone_cfg_t [2:0] zoneCfg;
  logic [2:0] absOver;
  logic [2:0] fanOnNow;
  logic [2:0] holdNow;
  logic lockedWrite;

  // read path
  logic [7:0] readMux;
  logic [7:0] next_rdData;
  logic next_rdValid;

  // registered outputs
  logic [2:0] next_fullDuty;
  logic [2:0] next_fanOn;
  logic [2:0] next_holdMin;
  logic next_xorTreeEnable;
  logic [3:0][15:0] next_tachReport;
  tach_ctl_t [3:0] next_tachCtl;
  logic [3:0][12:0] next_minRpm;

  // lock only gates the limit, hysteresis and test registers, never the tach mode register
  assign lockedWrite = regReq.write && !lockBit; // [R5]

  // register writes; reserved bits are masked off so they always read back zero
  always_comb begin
    next_absReg = absReg;
    next_hyst12Reg = hyst12Reg;
    next_hyst3Reg = hyst3Reg;
    next_testReg = testReg;
    next_tachReg = tachReg;
    if (lockedWrite) begin // [R5]
      case (regReq.addr)
        ADDR_ABS1: next_absReg[0] = regReq.wdata;
        ADDR_ABS2: next_absReg[1] = regReq.wdata;
        ADDR_ABS3: next_absReg[2] = regReq.wdata;
        ADDR_HYST12: next_hyst12Reg = regReq.wdata;
        ADDR_HYST3: next_hyst3Reg = regReq.wdata & MASK_HYST3; // [R20]
        ADDR_TEST: next_testReg = regReq.wdata & MASK_TEST; // [R9] [R20]
        default: ;
      endcase
    end
    // other addresses, including the rest of the vendor range, are dropped
    if (regReq.write && regReq.addr == ADDR_TACH) begin
      next_tachReg = regReq.wdata & MASK_TACH; // [R17] [R20]
    end
  end

  // every register here has its own default, so none is left undefined at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      absReg <= {RST_ABS, RST_ABS, RST_ABS};
      hyst12Reg <= RST_HYST12;
      hyst3Reg <= RST_HYST3;
      testReg <= RST_TEST;
      tachReg <= RST_TACH; // [R10]
    end else begin
      absReg <= next_absReg;
      hyst12Reg <= next_hyst12Reg;
      hyst3Reg <= next_hyst3Reg;
      testReg <= next_testReg;
      tachReg <= next_tachReg;
    end
  end

  // until start is set the block runs on defaults, so half-programmed values never act
  assign absEff = startBit ? absReg : {RST_ABS, RST_ABS, RST_ABS}; // [R6]
  assign hyst12Eff = startBit ? hyst12Reg : RST_HYST12; // [R6]
  assign hyst3Eff = startBit ? hyst3Reg : RST_HYST3; // [R6]
  assign testEff = startBit ? testReg : RST_TEST; // [R6]
  assign tachEff = startBit ? tachReg : RST_TACH; // [R17]

  // zone configuration carriers
  always_comb begin
    zoneCfg[0].absLimit = absEff[0];
    zoneCfg[1].absLimit = absEff[1];
    zoneCfg[2].absLimit = absEff[2];
    zoneCfg[0].hyst = hyst12Eff[HYST1_LSB+:4]; // [R8]
    zoneCfg[1].hyst = hyst12Eff[HYST2_LSB+:4]; // [R8]
    zoneCfg[2].hyst = hyst3Eff[HYST3_LSB+:4]; // [R8]
  end

  // one evaluator per temperature zone
  genvar z;
  generate
    for (z = 0; z < 3; z++) begin : g_zone
      zone_fan_eval u_eval (
        .clk(clk),
        .rst_n(rst_n),
        .temp(zoneTemp[z]),
        .fanLimit(fanLimit[z]),
        .cfg(zoneCfg[z]),
        .fanOn(fanOnNow[z]),
        .holdMin(holdNow[z]),
        .absOver(absOver[z])
      );
    end
  endgenerate

  // full-duty override; the newer variant fans it out to every output in auto mode, the older keeps it local
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (variantB) begin
        next_fullDuty[i] = autoMode[i] && (|absOver); // [R1]
      end else begin
        next_fullDuty[i] = autoMode[i] && absOver[i]; // [R3]
      end
    end
    next_fanOn = fanOnNow; // [R18]
    next_holdMin = holdNow; // [R7]
    next_xorTreeEnable = testEff[XEN_BIT]; // [R9]
  end

  // tach mode decode, saturation and detectable-speed floor
  always_comb begin
    tach_mode_t m;
    m = TACH_PLAIN;
    for (int i = 0; i < 4; i++) begin
      m = tach_field(tachEff, 2'(i)); // [R11]
      next_tachCtl[i].lowSpeedExt = m[1]; // [R15]
      next_tachCtl[i].quietTune = (m == TACH_QUIET); // [R15]
      next_tachCtl[i].saturate = (m != TACH_PLAIN); // [R14]
      // plain mode passes the raw count even when it is meaningless
      if (m != TACH_PLAIN && tachSlow[i]) begin
        next_tachReport[i] = TACH_SATURATED; // [R14]
      end else begin
        next_tachReport[i] = tachRaw[i]; // [R13]
      end
      next_minRpm[i] = min_rpm(m, pwmFreqSel); // [R16]
    end
  end

  // read mux shows stored values, not the defaults in use before start
  always_comb begin
    case (regReq.addr)
      ADDR_ABS1: readMux = absReg[0];
      ADDR_ABS2: readMux = absReg[1];
      ADDR_ABS3: readMux = absReg[2];
      ADDR_HYST12: readMux = hyst12Reg;
      ADDR_HYST3: readMux = hyst3Reg;
      ADDR_TEST: readMux = testReg;
      ADDR_TACH: readMux = tachReg;
      default: readMux = RD_UNDEFINED; // [R19]
    endcase
    next_rdData = regReq.read ? readMux : rdData;
    next_rdValid = regReq.read;
  end

  // output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= RD_UNDEFINED;
      rdValid <= 1'b0;
      fullDuty <= 3'h0;
      fanOn <= 3'h0;
      holdMin <= 3'h0;
      xorTreeEnable <= 1'b0;
      tachReport <= '0;
      tachCtl <= '0;
      minRpm <= '0;
    end else begin
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      fullDuty <= next_fullDuty;
      fanOn <= next_fanOn;
      holdMin <= next_holdMin;
      xorTreeEnable <= next_xorTreeEnable;
      tachReport <= next_tachReport;
      tachCtl <= next_tachCtl;
      minRpm <= next_minRpm;
    end
  end

  // the pulse count per revolution is fixed for every mode
  assign pulsesPerRev = PULSES_PER_REV; // [R12]

  // checks
  property p_lock_hold;
    @(posedge clk) disable iff (!rst_n)
      (regReq.write && lockBit && regReq.addr == ADDR_ABS1) |=> $stable(absReg[0]);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked limit register changed"); // [R5]

  property p_start_default;
    @(posedge clk) disable iff (!rst_n)
      !startBit |-> (zoneCfg[2].absLimit == RST_ABS && zoneCfg[0].hyst == RST_HYST12[HYST1_LSB+:4]);
  endproperty
  a_start_default: assert property (p_start_default) else $error("default not used before start"); // [R6]

  property p_tach_unlocked;
    @(posedge clk) disable iff (!rst_n)
      (regReq.write && lockBit && regReq.addr == ADDR_TACH) |=> (tachReg == ($past(regReq.wdata) & MASK_TACH));
  endproperty
  a_tach_unlocked: assert property (p_tach_unlocked) else $error("tach mode write lost under lock"); // [R17]

  property p_undef_read;
    @(posedge clk) disable iff (!rst_n)
      (regReq.read && regReq.addr == 8'h70) |=> (rdValid && rdData == RD_UNDEFINED);
  endproperty
  a_undef_read: assert property (p_undef_read) else $error("undefined address read nonzero"); // [R19]

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      (regReq.read && regReq.addr == ADDR_TEST) |=> (rdData[7:1] == 7'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved test bits read nonzero"); // [R20]

  property p_full_all;
    @(posedge clk) disable iff (!rst_n)
      (variantB && autoMode == 3'h7 && absOver[0]) |=> (fullDuty == 3'h7);
  endproperty
  a_full_all: assert property (p_full_all) else $error("newer variant did not force all outputs"); // [R1]

  property p_full_local;
    @(posedge clk) disable iff (!rst_n)
      (!variantB && absOver == 3'h1 && autoMode == 3'h7) |=> (fullDuty == 3'h1);
  endproperty
  a_full_local: assert property (p_full_local) else $error("older variant forced wrong outputs"); // [R3]

  property p_disable;
    @(posedge clk) disable iff (!rst_n)
      (absEff[0] == ABS_DISABLE) |-> !absOver[0];
  endproperty
  a_disable: assert property (p_disable) else $error("disabled absolute limit still fired"); // [R2]

  property p_saturate;
    @(posedge clk) disable iff (!rst_n)
      (tachEff[FAN_SPEED_INPUT_2_LSB+:2] != 2'b00 && tachSlow[1]) |=> (tachReport[1] == TACH_SATURATED);
  endproperty
  a_saturate: assert property (p_saturate) else $error("slow fan not reported as all ones"); // [R14]

  property p_xor_enter;
    @(posedge clk) disable iff (!rst_n)
      (startBit && !lockBit && regReq.write && regReq.addr == ADDR_TEST) ##1 startBit
        |=> (xorTreeEnable == $past(regReq.wdata[XEN_BIT], 2));
  endproperty
  a_xor_enter: assert property (p_xor_enter) else $error("test mode bit not followed"); // [R9]

  c_full_all: cover property (@(posedge clk) disable iff (!rst_n) variantB && fullDuty == 3'h7);
  c_hold: cover property (@(posedge clk) disable iff (!rst_n) holdMin[0] ##1 !holdMin[0]);
  c_locked: cover property (@(posedge clk) disable iff (!rst_n) lockBit && regReq.write && regReq.addr == ADDR_TEST);

endmodule : fan_zone_limit_tach_mode_regs

// File: sim/reg_host_model.sv
// host model that issues strobe requests on the limit register port
`timescale 1ns/1ps
module reg_host_model (
  // clock
  input wire logic clk,
  // register port
  output fan_limit_pkg::reg_req_t regReq,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  import fan_limit_pkg::*;

  // idle until the first request
  initial regReq = '0;

  // one strobe cycle, dropped at the next edge so two requests never merge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq.write <= 1'b0;
  endtask : write_reg

  // the answer comes a cycle after the strobe; ok stays low if it never shows
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    regReq.read <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rdValid === 1'b1) begin
        ok = 1'b1;
        d = rdData;
      end
    end
  endtask : read_reg
endmodule : reg_host_model

// File: sim/fan_zone_limit_tach_mode_regs_tb.sv
// self-checking bench for the absolute limit, hysteresis, test and tach mode registers
`timescale 1ns/1ps
module fan_zone_limit_tach_mode_regs_tb;
  import fan_limit_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t regReq;
  logic [7:0] rdData;
  logic rdValid;
  logic lockBit = 1'b0;
  logic startBit = 1'b0;
  logic variantB = 1'b1;
  logic [2:0] autoMode = 3'h7;
  logic [2:0][7:0] zoneTemp = '0;
  logic [2:0][7:0] fanLimit = {3{8'h5a}};
  logic [2:0] fullDuty;
  logic [2:0] fanOn;
  logic [2:0] holdMin;
  logic xorTreeEnable;
  logic [2:0] pwmFreqSel = 3'h0;
  logic [3:0][15:0] tachRaw = {4{16'h0123}};
  logic [3:0] tachSlow = 4'h0;
  logic [3:0][15:0] tachReport;
  tach_ctl_t [3:0] tachCtl;
  logic [3:0][12:0] minRpm;
  logic [1:0] pulsesPerRev;
  int fails = 0;
  int nCompared = 0;
  logic [7:0] rstAddr [8] = '{ADDR_ABS1, ADDR_ABS2, ADDR_ABS3, ADDR_HYST12, ADDR_HYST3, ADDR_TEST, ADDR_TACH, 8'h70};
  logic [7:0] rstVal [8] = '{RST_ABS, RST_ABS, RST_ABS, RST_HYST12, RST_HYST3, RST_TEST, RST_TACH, 8'h00};

  // 50 MHz clock
  always #10 clk = ~clk;

  fan_zone_limit_tach_mode_regs u_fan_zone_limit_tach_mode_regs (
    .clk(clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData), .rdValid(rdValid),
    .lockBit(lockBit), .startBit(startBit), .variantB(variantB), .autoMode(autoMode),
    .zoneTemp(zoneTemp), .fanLimit(fanLimit), .fullDuty(fullDuty), .fanOn(fanOn), .holdMin(holdMin),
    .xorTreeEnable(xorTreeEnable), .pwmFreqSel(pwmFreqSel), .tachRaw(tachRaw), .tachSlow(tachSlow),
    .tachReport(tachReport), .tachCtl(tachCtl), .minRpm(minRpm), .pulsesPerRev(pulsesPerRev)
  );

  reg_host_model u_reg_host_model (
    .clk(clk), .regReq(regReq), .rdData(rdData), .rdValid(rdValid)
  );

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // a read that never answers ends the run rather than hanging it
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_reg_host_model.read_reg(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      stop_test();
    end else begin
      check({8'h00, d}, {8'h00, exp});
    end
  endtask : rd_check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_reg_host_model.write_reg(a, d);
  endtask : wr

  // registered outputs need two edges after an input change
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_check(rstAddr[i], rstVal[i]);
    end
    // start clear: programmed limit stored but defaults still steer the logic
    wr(ADDR_ABS1, 8'h10);
    @(posedge clk);
    zoneTemp[0] <= 8'h20;
    settle();
    check({13'h0, fullDuty}, 16'h0000);
    zoneTemp[0] <= 8'h65;
    settle();
    check({13'h0, fullDuty}, 16'h0007);
    zoneTemp[0] <= 8'h64;
    settle();
    check({13'h0, fullDuty}, 16'h0000);
    rd_check(ADDR_ABS1, 8'h10);
    // programmed values in use, both variants and per-output auto gating
    startBit <= 1'b1;
    zoneTemp[0] <= 8'h20;
    settle();
    check({13'h0, fullDuty}, 16'h0007);
    variantB <= 1'b0;
    settle();
    check({13'h0, fullDuty}, 16'h0001);
    variantB <= 1'b1;
    autoMode <= 3'h5;
    settle();
    check({13'h0, fullDuty}, 16'h0005);
    autoMode <= 3'h7;
    // signed limits and the disable code
    wr(ADDR_ABS1, 8'hce);
    zoneTemp[0] <= 8'h00;
    settle();
    check({13'h0, fullDuty}, 16'h0007);
    zoneTemp[0] <= 8'hc0;
    settle();
    check({13'h0, fullDuty}, 16'h0000);
    wr(ADDR_ABS1, ABS_DISABLE);
    zoneTemp[0] <= 8'h7f;
    settle();
    check({13'h0, fullDuty}, 16'h0000);
    // reserved bits, undefined address and test mode
    wr(ADDR_HYST3, 8'hff);
    wr(ADDR_TEST, 8'hff);
    wr(ADDR_TACH, 8'hff);
    wr(8'h71, 8'hff);
    rd_check(ADDR_HYST3, 8'hf0);
    rd_check(ADDR_TEST, 8'h01);
    rd_check(ADDR_TACH, 8'h3f);
    rd_check(8'h71, 8'h00);
    check({15'h0, xorTreeEnable}, 16'h0001);
    wr(ADDR_TEST, 8'h00);
    settle();
    check({15'h0, xorTreeEnable}, 16'h0000);
    // tach modes 00, 01, 10 on inputs 1, 2 and 3/4
    wr(ADDR_TACH, 8'h24);
    tachSlow <= 4'hf;
    settle();
    check(tachReport[1], TACH_SATURATED);
    check(tachReport[3], TACH_SATURATED);
    check({13'h0, tachCtl[2]}, 16'h0005);
    check({13'h0, tachCtl[1]}, 16'h0001);
    check({3'h0, minRpm[0]}, 16'h0349);
    check({3'h0, minRpm[2]}, 16'h00d2);
    check({14'h0, pulsesPerRev}, 16'h0002);
    check(tachReport[0], 16'h0123);
    tachSlow <= 4'h0;
    settle();
    check(tachReport[0], 16'h0123);
    wr(ADDR_TACH, 8'h3f);
    pwmFreqSel <= 3'h7;
    settle();
    check({13'h0, tachCtl[3]}, 16'h0007);
    check({3'h0, minRpm[3]}, 16'h01a4);
    // hysteresis band of zone 1 with its default of four degrees
    fanLimit[0] <= 8'h40;
    zoneTemp[0] <= 8'h40;
    settle();
    check({15'h0, fanOn[0]}, 16'h0001);
    zoneTemp[0] <= 8'h3e;
    settle();
    check({14'h0, fanOn[0], holdMin[0]}, 16'h0001);
    zoneTemp[0] <= 8'h3c;
    settle();
    check({15'h0, holdMin[0]}, 16'h0001);
    zoneTemp[0] <= 8'h3b;
    settle();
    check({15'h0, holdMin[0]}, 16'h0000);
    // zone 1 hysteresis zero: no band below the limit
    wr(ADDR_HYST12, 8'h04);
    zoneTemp[0] <= 8'h40;
    fanLimit[1] <= 8'h40;
    zoneTemp[1] <= 8'h40;
    settle();
    zoneTemp[0] <= 8'h3f;
    zoneTemp[1] <= 8'h3d;
    settle();
    check({15'h0, holdMin[0]}, 16'h0000);
    check({15'h0, holdMin[1]}, 16'h0001);
    // lock freezes the group except the tach mode register
    lockBit <= 1'b1;
    wr(ADDR_ABS1, 8'h33);
    wr(ADDR_TEST, 8'h01);
    wr(ADDR_HYST12, 8'h11);
    wr(ADDR_TACH, 8'h15);
    rd_check(ADDR_ABS1, ABS_DISABLE);
    rd_check(ADDR_TEST, 8'h00);
    rd_check(ADDR_HYST12, 8'h04);
    rd_check(ADDR_TACH, 8'h15);
    startBit <= 1'b0;
    tachSlow <= 4'hf;
    settle();
    check(tachReport[0], 16'h0123);
    stop_test();
  end
endmodule : fan_zone_limit_tach_mode_regs_tb
